// ---- src/io_adapter_pkg.sv ----
// Constants and carrier types for the cycle-steal device adapter
package io_adapter_pkg;
    // Control word fields, bit 15 being the word's most significant bit
    localparam int AREA_HI = 15;
    localparam int AREA_LO = 11;
    localparam int FUNC_HI = 10;
    localparam int FUNC_LO = 8;
    localparam int MOD_B15 = 0;
    localparam int LVL_HI  = 5;
    localparam int SCAN_HI = 15;
    localparam int SCAN_LO = 14;
    localparam int WC_HI   = 13;

    // Function codes
    localparam logic [2:0] FN_CONTROL    = 3'h4;
    localparam logic [2:0] FN_SENSE_INT  = 3'h3;
    localparam logic [2:0] FN_SENSE_DEV  = 3'h7;
    localparam logic [2:0] FN_INIT_WRITE = 3'h5;
    localparam logic [2:0] FN_INIT_READ  = 3'h6;

    // Scan control encodings
    localparam logic [1:0] SC_SINGLE_INT  = 2'h0;
    localparam logic [1:0] SC_SINGLE_QUIET = 2'h1;

    // Register offsets of the adapter's own APB map
    localparam logic [7:0] OFS_CFG     = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_OUTDATA = 8'h08;
    localparam logic [7:0] OFS_INDATA  = 8'h0c;
    localparam logic [7:0] OFS_CTLLOG  = 8'h10;

    // Reset values and count constants
    localparam logic [19:0] CFG_RESET = 20'h00000;
    localparam logic [13:0] WC_ZERO   = 14'h0000;
    localparam logic [13:0] WC_ONE    = 14'h0001;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_FIRST    = 3'b001,
        ST_DATA     = 3'b010,
        ST_CH_ADDR  = 3'b011,
        ST_CH_CHECK = 3'b100,
        ST_CH_CTRL  = 3'b101
    } chan_state_type;

    // Processor to adapter
    typedef struct packed {
        logic [15:0] out_bus;
        logic        e_one;
        logic        e_two;
        logic        cs_grant;
    } proc_side_type;

    // Adapter to processor
    typedef struct packed {
        logic [15:0] in_bus;
        logic        cs_req;
        logic        int_req;
    } adapter_side_type;
endpackage : io_adapter_pkg

// ---- src/io_adapter.sv ----
// Cycle-stealing device adapter on the out-bus and in-bus, with an APB register port
//
// Notes on behaviour
// R1: Decode area, function, modifier in first cycle
// R2: Control may use address word second cycle
// R3: Processor ends instruction after second cycle
// R4: Level status word on in-bus, second cycle
// R5: Processor puts active level on modifier
// R6: Clear indicators only after gated out
// R7: Device status word, one bit per indicator
// R8: OR device conditions onto one level bit
// R9: Software senses device by its area
// R10: Channel runs only in run/trace mode
// R11: Each steal takes one storage cycle
// R12: Pending steals serviced before program resumes
// R13: Scan bits 0-1 of header word
// R14: Scan control selects stop or chain
// R15: Initialize loads and checks channel address
// R16: Address register then buffer address storage
// R17: First steal loads scan and count
// R18: Later steals move word, decrement count
// R19: Count zero ends; no more requests
// R20: Chaining takes three header cycles
// R21: Next table's first word is own address
// R22: At most three cycles between chained data
// R23: Function codes 100,011,111,101,110
// R24: Five-bit area selects device
// R25: Drive in-bus only on own sense
`timescale 1ns/10ps
module io_adapter
    import io_adapter_pkg::*;
(
    // Clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [7:0]                      paddr,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // Processor channel
    input  wire io_adapter_pkg::proc_side_type    proc_in,
    output io_adapter_pkg::adapter_side_type      proc_out
);
    chan_state_type state_q;
    logic [19:0] cfg_q;          // Area [4:0], level [13:8], level bit [19:16]
    logic [1:0]  scan_q;
    logic [13:0] wc_q;
    logic        write_dir_q;    // High: storage to device
    logic        end_ind_q;
    logic        short_ind_q;
    logic [15:0] out_data_q;
    logic        out_full_q;
    logic [15:0] in_data_q;
    logic        in_full_q;
    logic [15:0] ctl_mod_q;
    logic [15:0] ctl_addr_q;
    logic        ctl_pend_q;
    logic [15:0] bus_word;
    logic [2:0]  fn;
    logic        mine;
    logic        lvl_hit;
    logic        wr_acc;
    logic        rd_acc;
    logic        grant;
    logic        want;
    logic        last_word;
    logic [15:0] device_status_word;
    logic [15:0] lsw;
    logic [15:0] in_bus_c;

    // Own area match on the five-bit field
    function automatic logic area_hit(input logic [15:0] w, input logic [4:0] a);
        return w[AREA_HI:AREA_LO] == a;
    endfunction : area_hit

    // Control word decode
    assign bus_word = proc_in.out_bus;
    assign fn       = bus_word[FUNC_HI:FUNC_LO];                         // [R23]
    assign mine     = area_hit(bus_word, cfg_q[4:0]);                    // [R24] [R9]
    assign lvl_hit  = bus_word[LVL_HI:0] == cfg_q[13:8];
    assign grant    = proc_in.cs_grant & want;                           // [R11] [R16]
    assign last_word = wc_q == WC_ONE;

    // APB strobes; zero wait states
    // Every access completes in its first access cycle, so no stall logic
    assign wr_acc  = psel & penable & pwrite;
    assign rd_acc  = psel & penable & ~pwrite;
    assign pready  = 1'b1;

    // Registered function and hits of the first execute cycle
    logic [2:0] fn_q;
    logic       mine_q;
    logic       lvl_q;
    logic       clr_q;
    // Decode latched in the first cycle, used in the second
    // The out-bus carries other words later, so the decode must be held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fn_q   <= 3'h0;
            mine_q <= 1'b0;
            lvl_q  <= 1'b0;
            clr_q  <= 1'b0;
        end else if (proc_in.e_one) begin
            fn_q   <= fn;                                                // [R1]
            mine_q <= mine;
            lvl_q  <= lvl_hit;                                           // [R5]
            clr_q  <= bus_word[MOD_B15];
        end
    end

    // Status words
    assign device_status_word = {end_ind_q, short_ind_q, out_full_q, in_full_q, 12'h000};  // [R7]
    always_comb begin
        lsw = 16'h0000;
        lsw[cfg_q[19:16]] = end_ind_q | short_ind_q;                     // [R8]
    end

    // In-bus is quiet unless this adapter is being sensed or read
    // Status stands in the second execute cycle only; no third one follows
    always_comb begin
        in_bus_c = 16'h0000;
        if (proc_in.e_two && fn_q == FN_SENSE_INT && lvl_q) begin       // [R3]
            in_bus_c = lsw;                                              // [R4] [R25]
        end else if (proc_in.e_two && fn_q == FN_SENSE_DEV && mine_q) begin
            in_bus_c = device_status_word;                                              // [R7] [R25]
        end else if (grant && state_q == ST_DATA && !write_dir_q) begin
            in_bus_c = in_data_q;                                        // [R18]
        end
    end

    // Steal requests: header cycles always, data cycles when a word is ready
    // Header steals never wait on software, which keeps chaining gaps short
    always_comb begin
        unique case (state_q)
            ST_IDLE:  want = 1'b0;                                       // [R19]
            ST_DATA:  want = write_dir_q ? ~out_full_q : in_full_q;
            default:  want = 1'b1;                                       // [R20] [R22]
        endcase
    end
    // Request stays up until each pending word is served
    // One assignment drives the whole carrier, avoiding split drivers
    assign proc_out = '{in_bus: in_bus_c, cs_req: want, int_req: end_ind_q | short_ind_q};  // [R8] [R12]

    // Channel sequencing
    // Advances only on granted steals, so it idles whenever the processor
    // leaves run mode and stops granting
    // An initialise in mid-table abandons the old table
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= ST_IDLE;
            write_dir_q <= 1'b0;
        end else if (proc_in.e_one && mine && (fn == FN_INIT_WRITE || fn == FN_INIT_READ)) begin
            state_q     <= ST_FIRST;                                     // Reinitialise restarts [R15]
            write_dir_q <= fn == FN_INIT_WRITE;
        end else if (grant) begin                                        // [R10]
            unique case (state_q)
                ST_FIRST, ST_CH_CTRL: begin
                    // Empty table ends at once
                    if (bus_word[WC_HI:0] != WC_ZERO) begin
                        state_q <= ST_DATA;                              // [R17]
                    end else if (bus_word[SCAN_HI]) begin
                        state_q <= ST_CH_ADDR;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    if (last_word) begin
                        state_q <= scan_q[1] ? ST_CH_ADDR : ST_IDLE;     // [R14] [R19]
                    end
                end
                ST_CH_ADDR:  state_q <= ST_CH_CHECK;                     // [R20]
                ST_CH_CHECK: state_q <= ST_CH_CTRL;                      // [R21]
                default:     state_q <= ST_IDLE;
            endcase
        end
    end

    // Scan control and word count
    // Count is reloaded by the first steal and by the chained control steal, not by the address and check steals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_q <= 2'h0;
            wc_q   <= WC_ZERO;
        end else if (grant && (state_q == ST_FIRST || state_q == ST_CH_CTRL)) begin
            scan_q <= bus_word[SCAN_HI:SCAN_LO];                         // [R13] [R17]
            wc_q   <= bus_word[WC_HI:0];
        end else if (grant && state_q == ST_DATA) begin
            wc_q   <= wc_q - WC_ONE;                                     // [R18]
        end
    end

    // End-of-table indicator; a set in the clearing cycle wins
    // Losing an end event would leave software waiting forever
    logic table_end;
    assign table_end = grant && ((state_q == ST_DATA && last_word)
                     || ((state_q == ST_FIRST || state_q == ST_CH_CTRL) && bus_word[WC_HI:0] == WC_ZERO));
    logic end_irq;
    logic [1:0] sc_now;
    assign sc_now  = state_q == ST_DATA ? scan_q : bus_word[SCAN_HI:SCAN_LO];
    assign end_irq = table_end && (sc_now == SC_SINGLE_INT || sc_now[1] && !sc_now[0]);  // [R14]
    logic sense_clear;
    assign sense_clear = proc_in.e_two && fn_q == FN_SENSE_DEV && mine_q && clr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            end_ind_q   <= 1'b0;
            short_ind_q <= 1'b0;
        end else begin
            // Clearing takes effect at the end of the gating cycle
            if (end_irq) begin
                end_ind_q <= 1'b1;
            end else if (sense_clear) begin
                end_ind_q <= 1'b0;                                       // [R6]
            end
            // Quiet end of table leaves the test interrupt alone
            if (proc_in.e_one && mine && fn == FN_CONTROL && bus_word[MOD_B15]) begin
                short_ind_q <= 1'b1;                                     // Software test interrupt
            end else if (sense_clear) begin
                short_ind_q <= 1'b0;                                     // [R6]
            end
        end
    end

    // Data words, outbound and inbound; in each the set wins over the clear
    // One word each way only: the channel waits on software rather than
    // losing a word, at the cost of longer gaps between data steals
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data_q <= 16'h0000;
            out_full_q <= 1'b0;
        end else if (grant && state_q == ST_DATA && write_dir_q) begin
            out_data_q <= bus_word;                                      // [R18]
            out_full_q <= 1'b1;
        end else if (rd_acc && paddr == OFS_OUTDATA) begin
            out_full_q <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_data_q <= 16'h0000;
            in_full_q <= 1'b0;
        end else if (wr_acc && paddr == OFS_INDATA && !in_full_q) begin
            in_data_q <= pwdata[15:0];
            in_full_q <= 1'b1;
        end else if (grant && state_q == ST_DATA && !write_dir_q) begin
            in_full_q <= 1'b0;
        end
    end

    // Control command capture: modifier in cycle one, address word in cycle two
    // A second command before the log is read overwrites the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_mod_q  <= 16'h0000;
            ctl_addr_q <= 16'h0000;
            ctl_pend_q <= 1'b0;
        end else begin
            if (proc_in.e_one && mine && fn == FN_CONTROL) begin
                ctl_mod_q  <= bus_word;                                  // [R1]
                ctl_pend_q <= 1'b1;
            end else if (rd_acc && paddr == OFS_CTLLOG) begin
                ctl_pend_q <= 1'b0;
            end
            if (proc_in.e_two && mine_q && fn_q == FN_CONTROL) begin
                ctl_addr_q <= bus_word;                                  // [R2]
            end
        end
    end

    // Configuration register
    // Area and level take effect at the next execute cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RESET;
        end else if (wr_acc && paddr == OFS_CFG) begin
            cfg_q <= pwdata[19:0];
        end
    end

    // APB read mux and unmapped-address error
    // Mux only; clearing reads act in the data and control blocks
    // Status shows only the low byte of the count
    // Unaligned offsets fall to the error leg as well
    always_comb begin
        prdata  = 32'h00000000;
        pslverr = 1'b0;
        unique case (paddr)
            OFS_CFG:     prdata = {12'h000, cfg_q};
            OFS_STATUS:  prdata = {device_status_word, 3'h0, state_q, scan_q, wc_q[7:0]};
            OFS_OUTDATA: prdata = {16'h0000, out_data_q};
            OFS_INDATA:  prdata = {16'h0000, in_data_q};
            OFS_CTLLOG:  prdata = {ctl_addr_q[14:0], ctl_pend_q, ctl_mod_q};
            default:     pslverr = psel & penable;
        endcase
    end
endmodule : io_adapter

// ---- test/io_adapter_props.sv ----
// Port checker for the cycle-steal adapter
`timescale 1ns/10ps
module io_adapter_props
    import io_adapter_pkg::*;
(
    // Clock, reset and APB
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [7:0]                       paddr,
    input wire logic [31:0]                      pwdata,
    input wire logic [31:0]                      prdata,
    input wire logic                             pready,
    input wire logic                             pslverr,
    // Processor channel
    input wire io_adapter_pkg::proc_side_type    proc_in,
    input wire io_adapter_pkg::adapter_side_type proc_out
);
    logic [19:0] cfg_q;
    logic [15:0] cw_q;
    logic        own_w;
    logic        sd_w;

    // Shadow of the setup word, since the checker cannot see inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cfg_q <= 20'h00000;
        else if (psel && penable && pwrite && pready && paddr == OFS_CFG) cfg_q <= pwdata[19:0];
    end
    // Control word of the last first execute cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cw_q <= 16'h0000;
        else if (proc_in.e_one) cw_q <= proc_in.out_bus;
    end
    // Own-area sense device in the second execute cycle
    assign own_w = cw_q[15:11] == cfg_q[4:0];
    assign sd_w  = proc_in.e_two && own_w && cw_q[10:8] == FN_SENSE_DEV;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_bus_idle: assert property (
        !proc_in.e_two && !proc_in.cs_grant |-> proc_out.in_bus == 16'h0000) else $error("in-bus busy while idle");
    chk_apb_ready: assert property (
        psel && penable |-> pready) else $error("access phase not answered");
    chk_apb_error: assert property (
        psel && penable && paddr > OFS_CTLLOG |-> pslverr) else $error("unmapped access without error");
    chk_level_word: assert property (
        proc_in.e_two && cw_q[10:8] == FN_SENSE_INT && cw_q[5:0] == cfg_q[13:8]
        |-> proc_out.in_bus[cfg_q[19:16]] == proc_out.int_req) else $error("level status bit wrong");
    chk_dev_status: assert property (
        sd_w |-> (|proc_out.in_bus[15:14]) == proc_out.int_req) else $error("device status word wrong");
    chk_sense_clear: assert property (
        sd_w && cw_q[0] && !proc_in.cs_grant |=> ##1 !proc_out.int_req) else $error("indicators not cleared");
    chk_chan_start: assert property (
        proc_in.e_one && proc_in.out_bus[15:11] == cfg_q[4:0]
        && (proc_in.out_bus[10:8] == FN_INIT_WRITE || proc_in.out_bus[10:8] == FN_INIT_READ)
        |-> ##[1:2] proc_out.cs_req) else $error("channel did not request");
    chk_control_act: assert property (
        proc_in.e_one && proc_in.out_bus[15:11] == cfg_q[4:0] && proc_in.out_bus[10:8] == FN_CONTROL
        && proc_in.out_bus[0] |-> ##[1:3] proc_out.int_req) else $error("control action missing");
endmodule : io_adapter_props

bind io_adapter io_adapter_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .proc_in(proc_in), .proc_out(proc_out));

// ---- test/proc_model.sv ----
// Processor channel model: execute cycles, storage and cycle steals
`timescale 1ns/10ps
module proc_model
    import io_adapter_pkg::*;
(
    // Clock, reset and pacing
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             slow,
    // Adapter link
    output io_adapter_pkg::proc_side_type        proc_in,
    input wire io_adapter_pkg::adapter_side_type proc_out
);
    logic [15:0] mem [0:63];
    logic [15:0] car_q;
    logic [13:0] wc_q;
    logic [1:0]  scan_q;
    logic [2:0]  phase_q;
    logic [5:0]  st_a_q;
    logic        rd_q, busy_q, tick_q, store_q, addr_err_q;

    initial begin
        proc_in = '0;
        {busy_q, tick_q, store_q, addr_err_q, rd_q} = 5'h00;
        phase_q = 3'd5;
        car_q = 16'h0000;
    end
    // One stolen cycle per grant, never two in a row; slow mode grants only while tick_q is high, at the same peak rate
    always @(posedge pclk) begin
        tick_q <= ~tick_q;
        store_q <= 1'b0;
        if (store_q) mem[st_a_q] <= proc_out.in_bus;
        if (!busy_q && presetn && proc_out.cs_req && !proc_in.cs_grant && (!slow || tick_q)) begin
            proc_in.cs_grant <= 1'b1;
            proc_in.out_bus <= mem[car_q[5:0]];
            car_q <= car_q + 16'h0001;
            case (phase_q)
                3'd0: begin
                    {scan_q, wc_q} <= mem[car_q[5:0]];
                    phase_q <= 3'd1;
                end
                3'd1: begin
                    store_q <= rd_q;
                    st_a_q <= car_q[5:0];
                    wc_q <= wc_q - WC_ONE;
                    if (wc_q == WC_ONE) phase_q <= scan_q[1] ? 3'd2 : 3'd5;
                end
                3'd2: begin
                    car_q <= mem[car_q[5:0]];
                    phase_q <= 3'd3;
                end
                3'd3: begin
                    addr_err_q <= mem[car_q[5:0]] != car_q;
                    phase_q <= 3'd0;
                end
                default: ;
            endcase
        end else begin
            proc_in.cs_grant <= 1'b0;
            if (!busy_q) proc_in.out_bus <= ~proc_in.out_bus; // Released bus never holds a value
        end
    end
    // Execute-I/O: control word, address word, then the instruction ends
    task automatic execute_io_instr(input logic [15:0] cw, input logic [15:0] aw, output logic [15:0] st);
        while (proc_out.cs_req) begin
            @(posedge pclk);
        end
        busy_q <= 1'b1;
        @(posedge pclk);
        proc_in.e_one <= 1'b1;
        proc_in.out_bus <= cw;
        @(posedge pclk);
        proc_in.e_one <= 1'b0;
        proc_in.e_two <= 1'b1;
        proc_in.out_bus <= aw;
        if (cw[10:8] == FN_INIT_WRITE || cw[10:8] == FN_INIT_READ) begin
            car_q <= aw;
            phase_q <= 3'd0;
            rd_q <= cw[10:8] == FN_INIT_READ;
        end
        @(posedge pclk);
        st = proc_out.in_bus;
        proc_in.e_two <= 1'b0;
        busy_q <= 1'b0;
        @(posedge pclk);
    endtask : execute_io_instr
endmodule : proc_model

// ---- test/tb_top.sv ----
// Self-checking bench for the cycle-steal adapter
`timescale 1ns/10ps
module tb_top;
    import io_adapter_pkg::*;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [15:0]      st;
    int               mismatches, check_count;
    int               idx [3] = '{9, 10, 18};  // Storage words of the write chain
    proc_side_type    proc_in;
    adapter_side_type proc_out;

    io_adapter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .proc_in(proc_in), .proc_out(proc_out));
    proc_model pm (.pclk(pclk), .presetn(presetn), .slow(slow), .proc_in(proc_in), .proc_out(proc_out));

    always #2.5 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer, then an idle edge before the next
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_status(input int b, input logic v);
        int n;
        n = 0;
        apb(1'b0, OFS_STATUS, 32'h0);
        while (rd[b] !== v && n < 100) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end
        check(rd[b], v);
    endtask : wait_status
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        stop_test();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
        {pm.mem[8], pm.mem[9], pm.mem[10], pm.mem[11]} = {16'h8002, 16'h1111, 16'h2222, 16'h0010};
        {pm.mem[16], pm.mem[17], pm.mem[18], pm.mem[32]} = {16'h0010, 16'h0001, 16'h3333, 16'h4002};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CFG, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check(err, 1'b1);
        apb(1'b1, OFS_CFG, 32'h0004_0203);
        apb(1'b0, OFS_CFG, 32'h0);
        check(rd, 32'h0004_0203);
        $display("test registers done");
        pm.execute_io_instr({5'h03, FN_INIT_WRITE, 8'h00}, 16'h0008, st);
        foreach (idx[k]) begin
            slow <= (idx[k] == 18);
            wait_status(29, 1'b1);
            apb(1'b0, OFS_OUTDATA, 32'h0);
            check(rd[15:0], pm.mem[idx[k]]);
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        check({rd[31], rd[12:10]}, {1'b1, ST_IDLE});
        check(pm.addr_err_q, 1'b0);
        $display("test write chain done");
        pm.execute_io_instr({5'h00, FN_SENSE_INT, 8'h02}, 16'h0, st);
        check(st, 16'h0010);
        pm.execute_io_instr({5'h00, FN_SENSE_INT, 8'h03}, 16'h0, st);
        check(st, 16'h0000);
        pm.execute_io_instr({5'h04, FN_SENSE_DEV, 8'h01}, 16'h0, st);
        check(st, 16'h0000);
        pm.execute_io_instr({5'h03, FN_SENSE_DEV, 8'h00}, 16'h0, st);
        check(st[15:14], 2'b10);
        pm.execute_io_instr({5'h03, FN_SENSE_DEV, 8'h01}, 16'h0, st);
        check(st[15:14], 2'b10);
        pm.execute_io_instr({5'h03, FN_SENSE_DEV, 8'h00}, 16'h0, st);
        check({st[15:14], proc_out.int_req}, 3'b000);
        pm.execute_io_instr({5'h03, FN_CONTROL, 8'h01}, 16'h0123, st);
        pm.execute_io_instr({5'h03, FN_SENSE_DEV, 8'h01}, 16'h0, st);
        check(st[15:14], 2'b01);
        apb(1'b0, OFS_CTLLOG, 32'h0);
        check(rd, 32'h0247_1c01);
        apb(1'b0, OFS_CTLLOG, 32'h0);
        check(rd[16], 1'b0);
        $display("test sense and control done");
        pm.execute_io_instr({5'h03, FN_INIT_READ, 8'h00}, 16'h0020, st);
        apb(1'b1, OFS_INDATA, 32'h0000_beef);
        wait_status(28, 1'b0);
        apb(1'b1, OFS_INDATA, 32'h0000_1234);
        wait_status(28, 1'b0);
        check({pm.mem[33], pm.mem[34]}, 32'hbeef_1234);
        apb(1'b0, OFS_STATUS, 32'h0);
        check({rd[12:10], proc_out.int_req}, {ST_IDLE, 1'b0});
        $display("test read done");
        stop_test();
    end
endmodule : tb_top
